// ---- dv/wdtr_props.sv ----
// Port checker for the watchdog block.
// Assumes one clock and a synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module wdtr_props (
    input wire logic clock,
    input wire logic rst,
    input wire wdtr_pkg::wdtr_ctrl_t ctrl,
    input wire wdtr_pkg::wdtr_stat_t stat,
    input wire logic irq,
    input wire logic sys_reset
);
    import wdtr_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Cycles since the count was last cleared, and cycles the window has stood open
    logic [24:0] since_r;
    logic [9:0] open_r;
    wire logic [24:0] since_exp;
    assign since_exp = (ctrl.timeout_select == WDTR_SEL_15) ? 25'((1 << WDTR_EXP_SEL0) + 1) :
                       (ctrl.timeout_select == WDTR_SEL_18) ? 25'((1 << WDTR_EXP_SEL1) + 1) :
                       (ctrl.timeout_select == WDTR_SEL_21) ? 25'((1 << WDTR_EXP_SEL2) + 1) :
                       25'((1 << WDTR_EXP_SEL3) + 1);
    always_ff @(posedge clock) begin
        if (rst || ctrl.restart || !ctrl.enable) begin
            since_r <= '0;
        end else begin
            since_r <= since_r + 25'h0000001;
        end
    end
    always_ff @(posedge clock) begin
        if (rst || !stat.window_open) begin
            open_r <= '0;
        end else begin
            open_r <= open_r + 10'h001;
        end
    end
    // Output relations
    chk_pulse_one: assert property (sys_reset |=> !sys_reset) else $error("long pulse");
    chk_rst_after_win: assert property (sys_reset |-> $past(stat.window_open)) else $error("no window");
    chk_win_min: assert property ($rose(stat.window_open) |-> !sys_reset [*8]) else $error("early");
    chk_win_flag: assert property ($rose(stat.window_open) |-> stat.irq_flag) else $error("no flag");
    chk_restart_cancel: assert property (ctrl.restart |=> !stat.window_open && !sys_reset)
        else $error("not cancelled");
    chk_irq_gate: assert property (!ctrl.irq_enable |=> !irq) else $error("ungated");
    chk_flag_hold: assert property (stat.irq_flag && !ctrl.irq_clear |=> stat.irq_flag) else $error("lost");
    chk_enable_off: assert property (!ctrl.enable |=> !stat.window_open && !sys_reset) else $error("off");
    chk_open_time: assert property ($rose(stat.window_open) |-> since_r == since_exp)
        else $error("window opened off time");
    chk_win_len: assert property (sys_reset |-> open_r == WDTR_RST_WINDOW)
        else $error("window length wrong");
endmodule
bind wdtr_top wdtr_props u_props (.clock(clock), .rst(rst), .ctrl(ctrl), .stat(stat), .irq(irq),
    .sys_reset(sys_reset));
`default_nettype wire

// ---- dv/wdtr_top_tb_top.sv ----
// Testbench for the watchdog block.
// Assumes the checker is bound to the top module.
`timescale 1ns/10ps
`default_nettype none
module wdtr_top_tb_top;
    import wdtr_pkg::*;
    logic clock = 0;
    logic rst = 1;
    logic irq, sys_reset, seen;
    wdtr_ctrl_t ctrl = '0;
    wdtr_stat_t stat;
    int error_cnt = 0;
    int comparisons = 0;
    int n;
    wdtr_top u_dut (.clock(clock), .rst(rst), .ctrl(ctrl), .stat(stat), .irq(irq), .sys_reset(sys_reset));
    // Clock
    initial begin
        forever #12.5 clock = ~clock;
    end
    // Interval length for a select code
    function automatic int ivl(input int s);
        return 1 << (15 + 3 * s);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One-cycle restart, entered at a falling edge
    task automatic kick();
        ctrl.restart = 1;
        @(negedge clock);
        ctrl.restart = 0;
    endtask
    // Bounded wait for the flag (0) or the reset pulse (1)
    task automatic wait_on(input int w);
        n = 0;
        while (!(w ? sys_reset : stat.irq_flag) && n < 40000) begin
            @(negedge clock);
            n++;
        end
    endtask
    // Main sequence
    initial begin
        void'($urandom(96483));
        repeat (4) @(negedge clock);
        rst = 0;
        seen = 0;
        // Waits add up past the shortest interval, so only the restarts keep it quiet
        for (int i = 0; i < 8; i++) begin
            ctrl.enable = 1'b1;
            ctrl.timeout_select = (i < 7) ? 2'($urandom) : WDTR_SEL_15;
            ctrl.irq_enable = 1'($urandom);
            kick();
            repeat (4097 + $urandom % 32) begin
                @(negedge clock);
                seen |= stat.window_open | sys_reset | stat.irq_flag;
            end
        end
        chk(seen, 0, "early_fire");
        $display("timely restart test done");
        ctrl = '0;
        ctrl.enable = 1;
        ctrl.irq_enable = 1;
        kick();
        wait_on(0);
        chk(n >= ivl(0) && n <= ivl(0) + 2, 1, "flag_time");
        @(negedge clock);
        chk(irq, 1, "irq");
        wait_on(1);
        chk(n + 1, 512, "reset_delay");
        chk(stat.sys_reset, 1, "stat_reset");
        chk(stat.irq_flag, 1, "flag_sticky");
        ctrl.irq_clear = 1;
        @(negedge clock);
        ctrl.irq_clear = 0;
        repeat (2) @(negedge clock);
        chk({stat.irq_flag, irq}, 0, "flag_clear");
        $display("expiry test done");
        ctrl.irq_enable = 0;
        kick();
        wait_on(0);
        @(negedge clock);
        chk(irq, 0, "irq_gated");
        repeat (100) @(negedge clock);
        kick();
        seen = 0;
        // Covers the point where the reset would have come, 410 cycles after the restart
        repeat (450) begin
            @(negedge clock);
            seen |= sys_reset | stat.window_open;
        end
        chk({seen, stat.irq_flag}, 1, "cancel");
        ctrl.enable = 0;
        repeat (2) @(negedge clock);
        chk({stat.window_open, stat.sys_reset, sys_reset}, 0, "disabled");
        $display("window restart test done");
        tally_and_finish();
    end
    // Hang guard: three full shortest intervals plus windows take under 99,700 cycles
    initial begin
        repeat (100500) @(posedge clock);
        error_cnt++;
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ---- hdl/wdtr_expire.sv ----
// Interval decode: flags the terminal count of the selected watchdog interval.
// Assumes the count starts at zero on every restart.
`timescale 1ns/10ps
`default_nettype none
module wdtr_expire (
    input wire logic clock,
    input wire logic rst,
    input wire logic [1:0] timeout_select,
    input wire logic [23:0] count,
    output logic expire
);
    import wdtr_pkg::*;

    // Terminal value per select code, 2^n - 1
    wire logic [23:0] term_value;
    assign term_value = (timeout_select == WDTR_SEL_15) ? 24'((1 << WDTR_EXP_SEL0) - 1) :
                        (timeout_select == WDTR_SEL_18) ? 24'((1 << WDTR_EXP_SEL1) - 1) :
                        (timeout_select == WDTR_SEL_21) ? 24'((1 << WDTR_EXP_SEL2) - 1) :
                        24'((1 << WDTR_EXP_SEL3) - 1);

    wire logic hit;
    assign hit = (count == term_value);

    // Registered one-cycle pulse on terminal count
    always_ff @(posedge clock) begin
        if (rst) begin
            expire <= 1'b0;
        end else begin
            expire <= hit;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/wdtr_pkg.sv ----
// Package for the watchdog timeout/reset block: field widths, codes and timing counts.
// Assumes a single 40 MHz system clock and a synchronous active-high reset.
package wdtr_pkg;

    // Main counter covers the longest interval, 2^24 cycles
    localparam int WDTR_CNT_W = 24;
    localparam int WDTR_SEL_W = 2;

    // Interval exponents for each select code
    localparam int WDTR_EXP_SEL0 = 15;
    localparam int WDTR_EXP_SEL1 = 18;
    localparam int WDTR_EXP_SEL2 = 21;
    localparam int WDTR_EXP_SEL3 = 24;

    // Select codes
    localparam logic [1:0] WDTR_SEL_15 = 2'h0;
    localparam logic [1:0] WDTR_SEL_18 = 2'h1;
    localparam logic [1:0] WDTR_SEL_21 = 2'h2;
    localparam logic [1:0] WDTR_SEL_24 = 2'h3;

    // Window from interrupt timeout to reset timeout, in system clocks
    localparam int WDTR_WIN_W = 10;
    localparam logic [9:0] WDTR_RST_WINDOW = 10'h200;

    // Reset values
    localparam logic [23:0] WDTR_CNT_RST = 24'h000000;
    localparam logic [9:0] WDTR_WIN_RST = 10'h000;

    // Control inputs from software
    typedef struct packed {
        logic enable;
        logic restart;
        logic irq_enable;
        logic irq_clear;
        logic [1:0] timeout_select;
    } wdtr_ctrl_t;

    // Status outputs
    typedef struct packed {
        logic irq_flag;
        logic window_open;
        logic sys_reset;
    } wdtr_stat_t;

    typedef enum logic [1:0] {
        WDTR_COUNT,
        WDTR_WINDOW,
        WDTR_FIRE
    } wdtr_state_t;

endpackage

// ---- hdl/wdtr_top.sv ----
// Watchdog timer with interval interrupt and delayed system reset.
// Assumes software drives the control struct synchronously on the same clock.
// Behaviour
// - Free-running counter; timely restarts prevent any interrupt or reset.
// - Interrupt interval selectable from 2^15 to 2^24 system clocks.
// - Interval expiry sets interrupt request only when interrupt enable is set.
// - Reset timeout comes exactly 512 clocks after the interrupt timeout.
// - No restart within the window gives a full system reset at its end.
// - Two-bit select picks divisor 2^15, 2^18, 2^21 or 2^24.
`timescale 1ns/10ps
`default_nettype none
module wdtr_top (
    input wire logic clock,
    input wire logic rst,
    input wire wdtr_pkg::wdtr_ctrl_t ctrl,
    output wdtr_pkg::wdtr_stat_t stat,
    output logic irq,
    output logic sys_reset
);
    import wdtr_pkg::*;

    logic [23:0] count_r;
    logic [23:0] count_nxt;
    logic [9:0] win_r;
    logic [9:0] win_nxt;
    wdtr_state_t state_r;
    wdtr_state_t state_nxt;
    logic flag_r;
    logic irq_r;
    logic rst_out_r;
    logic stop_q_r;
    logic expire;

    // Terminal count detect for the selected interval
    wdtr_expire u_expire (
        .clock(clock),
        .rst(rst),
        .timeout_select(ctrl.timeout_select),
        .count(count_r),
        .expire(expire)
    );

    // Software restart, taken straight from the control struct
    wire logic restart_w;
    assign restart_w = ctrl.restart;

    // Anything that puts the count back to zero this cycle
    wire logic stop_w;
    assign stop_w = restart_w || !ctrl.enable;

    // Expiry pulse trails the count by one cycle; a clear just taken makes it stale
    wire logic stale_w;
    assign stale_w = stop_q_r;

    // Expiry that still counts: not stale and not stopped now
    wire logic expire_ok;
    assign expire_ok = expire && !stale_w && !stop_w;

    // State decodes
    wire logic in_count;
    assign in_count = (state_r == WDTR_COUNT);
    wire logic in_window;
    assign in_window = (state_r == WDTR_WINDOW);

    // Last cycle of the reset window, 511 cycles after it opened
    wire logic win_done;
    assign win_done = in_window && (win_r == WDTR_RST_WINDOW - 10'h001);

    // Interval expiry that opens the window and sets the flag
    wire logic irq_set;
    assign irq_set = expire_ok && in_count;

    // Window ran out with no restart: system reset
    wire logic fire_w;
    assign fire_w = win_done && !stop_w;

    // Sticky flag next value; a set in the clear cycle wins
    wire logic flag_nxt;
    assign flag_nxt = irq_set || (flag_r && !ctrl.irq_clear);

    // Interrupt request gated by its enable
    wire logic irq_nxt;
    assign irq_nxt = flag_nxt && ctrl.irq_enable;

    // Window indication follows the next state
    wire logic window_nxt;
    assign window_nxt = (state_nxt == WDTR_WINDOW);

    // Status word for the output register; flag mirrors the sticky flag exactly
    wire wdtr_stat_t stat_nxt;
    assign stat_nxt = {flag_nxt, window_nxt, fire_w};

    // Next count: free running, cleared by restart
    always_comb begin
        count_nxt = count_r + 24'h000001;
        if (restart_w || !ctrl.enable) begin
            count_nxt = WDTR_CNT_RST;
        end
    end

    // Sequence of interval, reset window and reset pulse
    always_comb begin
        state_nxt = state_r;
        win_nxt = win_r;
        case (state_r)
            WDTR_COUNT: begin
                win_nxt = WDTR_WIN_RST;
                if (irq_set) begin
                    state_nxt = WDTR_WINDOW;
                end
            end
            WDTR_WINDOW: begin
                win_nxt = win_r + 10'h001;
                if (restart_w || !ctrl.enable) begin
                    state_nxt = WDTR_COUNT;
                end else if (win_done) begin
                    state_nxt = WDTR_FIRE;
                end
            end
            WDTR_FIRE: begin
                state_nxt = WDTR_COUNT;
                win_nxt = WDTR_WIN_RST;
            end
            default: begin
                state_nxt = WDTR_COUNT;
                win_nxt = WDTR_WIN_RST;
            end
        endcase
    end

    // Interval count
    always_ff @(posedge clock) begin
        if (rst) begin
            count_r <= WDTR_CNT_RST;
        end else begin
            count_r <= count_nxt;
        end
    end

    // Reset window count
    always_ff @(posedge clock) begin
        if (rst) begin
            win_r <= WDTR_WIN_RST;
        end else begin
            win_r <= win_nxt;
        end
    end

    // Sequence state
    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= WDTR_COUNT;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Remembers a count clear for one cycle, so a trailing expiry is dropped
    always_ff @(posedge clock) begin
        if (rst) begin
            stop_q_r <= 1'b0;
        end else begin
            stop_q_r <= stop_w;
        end
    end

    // Sticky flag: set wins over software clear
    always_ff @(posedge clock) begin
        if (rst) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // Interrupt output register
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    // System reset output register, one cycle wide
    always_ff @(posedge clock) begin
        if (rst) begin
            rst_out_r <= 1'b0;
        end else begin
            rst_out_r <= fire_w;
        end
    end

    // Status output register
    always_ff @(posedge clock) begin
        if (rst) begin
            stat <= '0;
        end else begin
            stat <= stat_nxt;
        end
    end

    assign irq = irq_r;
    assign sys_reset = rst_out_r;
endmodule
`default_nettype wire
